// ===== core/gpio_cell_map.vh
// Register offsets, field positions and reset values of the I/O logic cell
`ifndef GPIO_CELL_MAP_VH
`define GPIO_CELL_MAP_VH

// Register byte offsets
`define CTRL_OFS      8'h00
`define DELAY_OFS     8'h04
`define STATUS_OFS    8'h08

// Control register fields
`define MODE_LSB      0
`define MODE_MSB      2
`define RX_REG_BIT    3
`define RX_NEG_BIT    4
`define TX_REG_BIT    5
`define TX_NEG_BIT    6
`define GATE_REG_BIT  7
`define GATE_NEG_BIT  8
`define TX_INV_BIT    9
`define DUAL_BIT      10
`define RESYNC_BIT    11
`define ALT_SEL_BIT   12
`define SERDES_BIT    13
`define PULL_DN_BIT   14
`define KIND_LSB      15
`define KIND_MSB      16
`define DYN_USE_BIT   17
`define USER_MODE_BIT 18
`define CTRL_RESET    32'h0000_0000

// Delay register fields
`define RX_DLY_LSB    0
`define RX_DLY_MSB    5
`define TX_DLY_LSB    8
`define TX_DLY_MSB    13
`define DELAY_RESET   32'h0000_0000

// Modes
`define MODE_UNUSED   3'h0
`define MODE_INPUT    3'h1
`define MODE_OUTPUT   3'h2
`define MODE_BIDIR    3'h3
`define MODE_CLKOUT   3'h4

// Pin kinds
`define KIND_HV       2'h0
`define KIND_FAST_SE  2'h1
`define KIND_FAST_DIF 2'h2

// Delay chain lengths in steps
`define STEPS_SHORT   7'h10
`define STEPS_LONG    7'h40

`endif

// ===== core/gpio_io_logic_cell.v
// General-purpose pin I/O logic cell with AHB-Lite configuration port
`timescale 1ns/10ps
`include "gpio_cell_map.vh"

// Behaviour
// - input mode: receive only, optional edge register
// - alternate input passes pad through one hclk register
// - dual-edge input samples both input clock edges
// - output mode: drive only, optional edge register
// - optional inversion of output register value
// - dual-edge output muxes two edge registers
// - bidir: input clock receive, output clock drive
// - bidir paths registered independently, either edge
// - clock-output mode forwards tree clock to pad
// - weak pull-up while being configured
// - unused pins pull-up, optionally pull-down
// - dual-edge core data is two bits
// - normal crosses both edges, resync rising only
// - resync delays falling sample half period
// - input bit0 rising sample, bit1 falling
// - output bit0 rising value, bit1 falling
// - short pins: 16-step static delay both paths
// - differential: 64-step static, no mixing receive
// - single-ended fast: dynamic delay receive only
// - differential delays act on positive leg
// - 1:4 serdes only on fast pins
// - static plus dynamic allowed on some pins
// - serdes bit0 first in time, bit3 last
module gpio_io_logic_cell #(
    parameter [5:0] DYN_INIT = 6'h00
) (
    // Bus clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // Sampled core clocks
    input  wire        in_clk,
    input  wire        out_clk,
    input  wire        tree_clk,
    // Core side
    input  wire [3:0]  tx_data,
    input  wire        tx_gate,
    input  wire        drive_gate_comp,
    input  wire        dyn_delay_enable,
    input  wire        dyn_delay_direction,
    input  wire        dyn_delay_clear,
    output wire [3:0]  rx_data,
    output wire        alt_out,
    // Pad side
    input  wire        pad_in,
    output wire        pad_out,
    output wire        pad_oe,
    output wire        pull_up,
    output wire        pull_down
);

    // Edge selected by a negative-edge flag
    function pick_edge;
        input neg;
        input rise;
        input fall;
        begin
            pick_edge = neg ? fall : rise;
        end
    endfunction

    // Clip a tap to the chain length of the pin kind
    function [5:0] clip_tap;
        input [6:0] tap;
        input       long_chain;
        reg   [6:0] lim;
        begin
            lim = long_chain ? `STEPS_LONG : `STEPS_SHORT;
            if (tap >= lim) begin
                clip_tap = lim[5:0] - 6'h01;
            end else begin
                clip_tap = tap[5:0];
            end
        end
    endfunction

    reg  [31:0] ctrl_q;
    reg  [31:0] delay_q;
    reg  [31:0] hrdata_q;
    reg         hreadyout_q;
    reg         wr_pend_q;
    reg  [7:0]  wr_addr_q;
    reg         in_clk_q;
    reg         out_clk_q;
    reg  [63:0] rx_hist_q;
    reg  [63:0] tx_hist_q;
    reg  [5:0]  dyn_q;
    reg  [3:0]  rx_data_q;
    reg  [3:0]  rx_sh_q;
    reg  [1:0]  rx_cnt_q;
    reg         fall_s_q;
    reg         alt_q;
    reg  [3:0]  tx_sh_q;
    reg  [1:0]  tx_cnt_q;
    reg         tx_bit_q;
    reg         tx_hold_q;
    reg         gate_q;
    reg         pad_out_q;
    reg         pad_oe_q;
    reg         pull_up_q;
    reg         pull_down_q;

    wire [2:0] mode      = ctrl_q[`MODE_MSB:`MODE_LSB];
    wire [1:0] kind      = ctrl_q[`KIND_MSB:`KIND_LSB];
    wire       user_mode = ctrl_q[`USER_MODE_BIT];
    wire       is_hv     = (kind == `KIND_HV);
    wire       is_dif    = (kind == `KIND_FAST_DIF);
    wire       rx_en     = (mode == `MODE_INPUT) || (mode == `MODE_BIDIR);
    wire       tx_en     = (mode == `MODE_OUTPUT) || (mode == `MODE_BIDIR);
    wire       serdes    = ctrl_q[`SERDES_BIT] && !is_hv;
    wire       dual      = ctrl_q[`DUAL_BIT];
    wire       resync    = ctrl_q[`RESYNC_BIT];
    wire       dyn_use   = ctrl_q[`DYN_USE_BIT] && !is_hv;
    wire       in_rise   = in_clk && !in_clk_q;
    wire       in_fall   = !in_clk && in_clk_q;
    wire       out_rise  = out_clk && !out_clk_q;
    wire       out_fall  = !out_clk && out_clk_q;
    wire       addr_ok   = hsel && hready && htrans[1];

    // Bus slave, zero wait states
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q   <= 1'b0;
            wr_addr_q   <= 8'h00;
            hrdata_q    <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
        end else begin
            hreadyout_q <= 1'b1;
            wr_pend_q   <= addr_ok && hwrite;
            wr_addr_q   <= haddr[7:0];
            if (addr_ok && !hwrite) begin
                case (haddr[7:0])
                    `CTRL_OFS:   hrdata_q <= ctrl_q;
                    `DELAY_OFS:  hrdata_q <= delay_q;
                    `STATUS_OFS: hrdata_q <= {14'h0000, pad_oe_q, pad_in,
                                              2'h0, dyn_q, 4'h0, rx_data_q};
                    default:     hrdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration registers, written in the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q  <= `CTRL_RESET;
            delay_q <= `DELAY_RESET;
        end else if (wr_pend_q) begin
            if (wr_addr_q == `CTRL_OFS) begin
                ctrl_q <= {13'h0000, hwdata[18:0]};
            end
            if (wr_addr_q == `DELAY_OFS) begin
                delay_q <= {18'h0_0000, hwdata[13:8], 2'h0, hwdata[5:0]};
            end
        end
    end

    // Dynamic delay counter, saturating
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dyn_q <= 6'h00;
        end else if (dyn_delay_clear) begin
            dyn_q <= DYN_INIT;
        end else if (dyn_delay_enable && dyn_use) begin
            if (dyn_delay_direction && dyn_q != 6'h3f) begin
                dyn_q <= dyn_q + 6'h01;
            end else if (!dyn_delay_direction && dyn_q != 6'h00) begin
                dyn_q <= dyn_q - 6'h01;
            end
        end
    end

    // Receive tap selection
    wire [6:0] rx_static = {1'b0, delay_q[`RX_DLY_MSB:`RX_DLY_LSB]};
    wire [6:0] tx_static = {1'b0, delay_q[`TX_DLY_MSB:`TX_DLY_LSB]};
    reg  [6:0] rx_tap;
    always @* begin
        if (is_hv) begin
            rx_tap = rx_static;
        end else if (is_dif) begin
            rx_tap = dyn_use ? {1'b0, dyn_q} : rx_static;
        end else begin
            rx_tap = rx_static + (dyn_use ? {1'b0, dyn_q} : 7'h00);
        end
    end

    wire rx_src = rx_hist_q[clip_tap(rx_tap, is_dif)];
    wire [5:0] tx_tap = clip_tap(tx_static, is_dif);

    // Receive delay chain, one hclk per step, and clock edge samples
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_hist_q <= 64'h0000_0000_0000_0000;
            in_clk_q  <= 1'b0;
            out_clk_q <= 1'b0;
        end else begin
            rx_hist_q <= {rx_hist_q[62:0], pad_in};
            in_clk_q  <= in_clk;
            out_clk_q <= out_clk;
        end
    end

    // Receive path
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_data_q <= 4'h0;
            rx_sh_q   <= 4'h0;
            rx_cnt_q  <= 2'h0;
            fall_s_q  <= 1'b0;
            alt_q     <= 1'b0;
        end else begin
            alt_q <= ctrl_q[`ALT_SEL_BIT] && pad_in;
            if (!rx_en) begin
                rx_cnt_q <= 2'h0;
            end else if (serdes) begin
                if (in_rise) begin
                    rx_sh_q  <= {rx_src, rx_sh_q[3:1]};
                    rx_cnt_q <= rx_cnt_q + 2'h1;
                    if (rx_cnt_q == 2'h3) begin
                        rx_data_q <= {rx_src, rx_sh_q[3:1]};
                    end
                end
            end else if (dual) begin
                if (in_fall) begin
                    fall_s_q <= rx_src;
                end
                if (resync) begin
                    if (in_rise) begin
                        rx_data_q <= {2'h0, fall_s_q, rx_src};
                    end
                end else begin
                    if (in_rise) begin
                        rx_data_q[0] <= rx_src;
                    end
                    if (in_fall) begin
                        rx_data_q[1] <= rx_src;
                    end
                end
            end else if (ctrl_q[`RX_REG_BIT]) begin
                if (pick_edge(ctrl_q[`RX_NEG_BIT], in_rise, in_fall)) begin
                    rx_data_q <= {3'h0, rx_src};
                end
            end else begin
                rx_data_q <= {3'h0, rx_src};
            end
        end
    end

    // Drive path
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_sh_q   <= 4'h0;
            tx_cnt_q  <= 2'h0;
            tx_bit_q  <= 1'b0;
            tx_hold_q <= 1'b0;
        end else if (!tx_en) begin
            tx_cnt_q <= 2'h0;
        end else if (serdes) begin
            if (out_rise) begin
                tx_cnt_q <= tx_cnt_q + 2'h1;
                if (tx_cnt_q == 2'h0) begin
                    tx_sh_q  <= tx_data;
                    tx_bit_q <= tx_data[0];
                end else begin
                    tx_bit_q <= tx_sh_q[tx_cnt_q];
                end
            end
        // two edge registers onto one stream
        end else if (dual) begin
            if (out_rise) begin
                tx_bit_q  <= tx_data[0];
                tx_hold_q <= tx_data[1];
            end
            if (out_fall) begin
                tx_bit_q <= resync ? tx_hold_q : tx_data[1];
            end
        end else if (ctrl_q[`TX_REG_BIT]) begin
            if (pick_edge(ctrl_q[`TX_NEG_BIT], out_rise, out_fall)) begin
                tx_bit_q <= tx_data[0];
            end
        end else begin
            tx_bit_q <= tx_data[0];
        end
    end

    wire tx_regd = serdes || dual || ctrl_q[`TX_REG_BIT];
    wire tx_val = tx_bit_q ^ (ctrl_q[`TX_INV_BIT] && tx_regd);
    wire pad_val = (mode == `MODE_CLKOUT) ? tree_clk : tx_val;
    wire gate_in = is_dif ? (tx_gate && drive_gate_comp) : tx_gate;

    // Drive gate
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_q <= 1'b0;
        end else begin
            case (mode)
                `MODE_OUTPUT: gate_q <= 1'b1;
                `MODE_CLKOUT: gate_q <= 1'b1;
                `MODE_BIDIR: begin
                    if (!ctrl_q[`GATE_REG_BIT]) begin
                        gate_q <= gate_in;
                    end else if (pick_edge(ctrl_q[`GATE_NEG_BIT],
                                           out_rise, out_fall)) begin
                        gate_q <= gate_in;
                    end
                end
                default: gate_q <= 1'b0;
            endcase
        end
    end

    // Pad stage; pulls and gate act at once, data sees the chain, clock-output mode bypasses it
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_hist_q   <= 64'h0000_0000_0000_0000;
            pad_out_q   <= 1'b0;
            pad_oe_q    <= 1'b0;
            pull_up_q   <= 1'b1;
            pull_down_q <= 1'b0;
        end else begin
            tx_hist_q <= {tx_hist_q[62:0], pad_val};
            pad_out_q <= (mode == `MODE_CLKOUT) ? pad_val : tx_hist_q[tx_tap];
            pad_oe_q  <= user_mode && gate_q && (mode != `MODE_UNUSED);
            if (!user_mode) begin
                pull_up_q   <= 1'b1;
                pull_down_q <= 1'b0;
            end else if (mode == `MODE_UNUSED) begin
                pull_up_q   <= !ctrl_q[`PULL_DN_BIT];
                pull_down_q <= ctrl_q[`PULL_DN_BIT];
            end else begin
                pull_up_q   <= 1'b0;
                pull_down_q <= 1'b0;
            end
        end
    end

    assign rx_data   = rx_data_q;
    assign alt_out   = alt_q;
    assign pad_out   = pad_out_q;
    assign pad_oe    = pad_oe_q;
    assign pull_up   = pull_up_q;
    assign pull_down = pull_down_q;
    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    // Every transfer answers OKAY
    assign hresp     = 1'b0;

endmodule

// ===== verif/gpio_io_logic_cell_assertions.sv
// Port checker for the I/O logic cell
`timescale 1ns/10ps
module gpio_cell_checker (
    // Bus
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    // Pad and core
    input wire        pad_in,
    input wire        alt_out,
    input wire        pad_oe,
    input wire        pull_up,
    input wire        pull_down
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire rd = hsel && hready && htrans[1] && !hwrite;

    a_ready_high: assert property (hreadyout)
        else $error("hreadyout low");
    a_resp_okay: assert property (rd |-> !hresp ##1 !hresp)
        else $error("error response");
    a_rdata_holds: assert property (!rd |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (rd && haddr[7:0] > 8'h08 |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_ctrl_upper: assert property (rd && haddr[7:0] == 8'h00 |=> hrdata[31:19] == 13'h0)
        else $error("control spare bits set");
    a_delay_gaps: assert property (rd && haddr[7:0] == 8'h04 |=> !hrdata[7:6] && !hrdata[31:14])
        else $error("delay spare bits set");
    a_alt_follows: assert property (alt_out |-> $past(pad_in))
        else $error("alternate output not from pad");
    a_pull_exclusive: assert property (!(pull_up && pull_down))
        else $error("both pulls on");
    a_drive_no_pull: assert property (pad_oe |-> !pull_up && !pull_down)
        else $error("pull while driving");

    cover property (pad_oe ##1 !pad_oe);
    cover property ($rose(pull_down));
    cover property ($rose(alt_out));
endmodule

bind gpio_io_logic_cell gpio_cell_checker gpio_cell_checker_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .pad_in, .alt_out, .pad_oe, .pull_up, .pull_down
);

// ===== verif/pad_model.sv
// Board-side model of the signal at the pad
`timescale 1ns/10ps
module pad_model (
    // Cell side
    input wire   pad_out,
    input wire   pad_oe,
    input wire   pull_up,
    input wire   pull_down,
    // Board source
    input wire   ext_en,
    input wire   ext_val,
    // Pad level
    output logic pad_in
);
    logic last;
    wire  driven = pad_oe || ext_en || pull_up || pull_down;
    always @* begin
        if (pad_oe) begin
            pad_in = pad_out;
        end else if (ext_en) begin
            pad_in = ext_val;
        end else if (pull_up || pull_down) begin
            pad_in = pull_up;
        end else begin
            // Floating: never repeat the last level
            pad_in = ~last;
        end
    end
    // Remember the last driven level
    always @(pad_in or driven) begin
        if (driven) begin
            last <= pad_in;
        end
    end
endmodule

// ===== verif/gpio_io_logic_cell_tb.sv
// Self-checking bench for the I/O logic cell
`timescale 1ns/10ps
`include "gpio_cell_map.vh"
module gpio_io_logic_cell_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [3:0]  tx_data = 4'h0;
    logic        in_clk = 1'b0;
    logic        out_clk = 1'b0;
    logic        tree_clk = 1'b0;
    logic        tx_gate = 1'b0;
    logic        dly_en = 1'b0;
    logic        dly_dir = 1'b0;
    logic        dly_clr = 1'b0;
    logic        ext_en = 1'b0;
    logic        ext_val = 1'b0;
    wire  [31:0] hrdata;
    wire  [3:0]  rx_data;
    wire         hreadyout, hresp, alt_out, pad_in, pad_out, pad_oe, pull_up, pull_down;
    int          errors = 0;
    int          checks = 0;
    int          cyc = 0;
    logic [31:0] r;
    localparam logic [31:0] U = 32'h1 << `USER_MODE_BIT;

    gpio_io_logic_cell gpio_io_logic_cell_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .in_clk(in_clk),
        .out_clk(out_clk), .tree_clk(tree_clk), .tx_data(tx_data), .tx_gate(tx_gate),
        .drive_gate_comp(tx_gate), .dyn_delay_enable(dly_en),
        .dyn_delay_direction(dly_dir), .dyn_delay_clear(dly_clr), .rx_data(rx_data),
        .alt_out(alt_out), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pull_up(pull_up), .pull_down(pull_down));
    pad_model pad_model_inst (.pad_out(pad_out), .pad_oe(pad_oe), .pull_up(pull_up),
        .pull_down(pull_down), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

    initial begin
        forever #2.5 hclk = ~hclk;
    end

    function automatic logic [31:0] b(input int n);
        return 32'h1 << n;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Single word transfer, waits on hready in both phases
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic cfg(input logic [31:0] v);
        bus(1'b1, `CTRL_OFS, v);
        tick(2);
    endtask

    task automatic step_in(input logic v);
        in_clk <= v;
        tick(4);
    endtask

    task automatic step_out(input logic v);
        out_clk <= v;
        tick(8);
    endtask

    task automatic t_regs;
        chk(pull_up, 1'b1);
        chk(pad_oe, 1'b0);
        bus(1'b0, `CTRL_OFS, 32'h0);
        chk(r, `CTRL_RESET);
        bus(1'b1, `CTRL_OFS, 32'hFFFF_FFFF);
        bus(1'b0, `CTRL_OFS, 32'h0);
        chk(r, 32'h0007_FFFF);
        bus(1'b1, `DELAY_OFS, 32'hFFFF_FFFF);
        bus(1'b0, `DELAY_OFS, 32'h0);
        chk(r, 32'h0000_3F3F);
        bus(1'b1, `DELAY_OFS, 32'h0);
        bus(1'b0, 8'h0C, 32'h0);
        chk(r, 32'h0000_0000);
        cfg(U | b(`PULL_DN_BIT));
        chk({pull_up, pull_down}, 2'b01);
        cfg(U);
        chk({pull_up, pull_down}, 2'b10);
        $display("done regs and pulls");
    endtask

    task automatic t_out;
        tx_data <= 4'h1;
        cfg(U | `MODE_OUTPUT | b(`TX_REG_BIT) | b(`TX_INV_BIT));
        step_out(1'b1);
        chk({pad_oe, pad_out}, 2'b10);
        tx_data <= 4'h2;
        step_out(1'b0);
        cfg(U | `MODE_OUTPUT | b(`DUAL_BIT));
        step_out(1'b1);
        chk(pad_out, 1'b0);
        step_out(1'b0);
        chk(pad_out, 1'b1);
        cfg(U | `MODE_CLKOUT);
        tree_clk <= 1'b1;
        tick(4);
        chk(pad_out, 1'b1);
        tree_clk <= 1'b0;
        tick(4);
        chk(pad_out, 1'b0);
        cfg(U);
        chk({pad_oe, pull_up}, 2'b01);
        $display("done drive");
    endtask

    task automatic t_bidir;
        ext_en <= 1'b1;
        ext_val <= 1'b1;
        cfg(U | `MODE_BIDIR);
        tick(4);
        chk({pad_oe, pull_up, rx_data[0]}, 3'b001);
        tx_gate <= 1'b1;
        tick(4);
        chk(pad_oe, 1'b1);
        tx_gate <= 1'b0;
        cfg(U | `MODE_INPUT | b(`ALT_SEL_BIT));
        tick(3);
        chk(alt_out, 1'b1);
        $display("done bidir");
    endtask

    task automatic t_in;
        logic [3:0] pat;
        pat = 4'hB;
        cfg(U | `MODE_INPUT | b(`DUAL_BIT) | b(`RESYNC_BIT));
        step_in(1'b1);
        step_in(1'b0);
        ext_val <= 1'b0;
        tick(4);
        step_in(1'b1);
        chk(rx_data, 4'h2);
        step_in(1'b0);
        cfg(U);
        cfg(U | `MODE_INPUT | b(`SERDES_BIT) | b(`KIND_LSB));
        for (int i = 0; i < 4; i++) begin
            ext_val <= pat[i];
            tick(4);
            step_in(1'b1);
            step_in(1'b0);
        end
        chk(rx_data, 4'hB);
        $display("done receive");
    endtask

    task automatic t_dyn;
        cfg(U | `MODE_INPUT | b(`KIND_LSB) | b(`DYN_USE_BIT));
        dly_en <= 1'b1;
        dly_dir <= 1'b1;
        tick(3);
        dly_dir <= 1'b0;
        tick(1);
        dly_en <= 1'b0;
        bus(1'b0, `STATUS_OFS, 32'h0);
        chk(r[13:8], 6'h02);
        dly_clr <= 1'b1;
        tick(1);
        dly_clr <= 1'b0;
        bus(1'b0, `STATUS_OFS, 32'h0);
        chk(r[13:8], 6'h00);
        $display("done delay");
    endtask

    task automatic t_rxreg;
        bus(1'b1, `DELAY_OFS, 32'h0000_0003);
        cfg(U | `MODE_INPUT | b(`RX_REG_BIT) | b(`RX_NEG_BIT));
        ext_val <= 1'b0;
        step_in(1'b1);
        ext_val <= 1'b1;
        tick(2);
        step_in(1'b0);
        // Fresh level still inside the three-step chain
        chk(rx_data, 4'h0);
        step_in(1'b1);
        chk(rx_data, 4'h0);
        step_in(1'b0);
        chk(rx_data, 4'h1);
        $display("done input register");
    endtask

    task automatic t_ser;
        logic [3:0] pat;
        pat = 4'hB;
        tx_data <= pat;
        cfg(U | `MODE_OUTPUT | b(`SERDES_BIT) | b(`KIND_LSB));
        for (int i = 0; i < 4; i++) begin
            step_out(1'b1);
            tx_data <= 4'h0;
            chk(pad_out, pat[i]);
            step_out(1'b0);
        end
        tx_data <= 4'hE;
        cfg(U | `MODE_OUTPUT | b(`SERDES_BIT));
        tick(2);
        chk(pad_out, 1'b0);
        cfg(U | `MODE_BIDIR | b(`GATE_REG_BIT) | b(`GATE_NEG_BIT));
        step_out(1'b1);
        chk(pad_oe, 1'b1);
        step_out(1'b0);
        chk(pad_oe, 1'b0);
        tx_gate <= 1'b1;
        step_out(1'b1);
        chk(pad_oe, 1'b0);
        step_out(1'b0);
        chk(pad_oe, 1'b1);
        tx_gate <= 1'b0;
        $display("done serializer and gate");
    endtask

    task automatic complete_run;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Whole run is well under two thousand cycles
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            complete_run();
        end
    end

    initial begin
        tick(16);
        hresetn <= 1'b1;
        t_regs();
        t_out();
        t_bidir();
        t_in();
        t_dyn();
        t_rxreg();
        t_ser();
        complete_run();
    end
endmodule
